// File: core/asrw_consts.svh
// Timing constants and field positions for the asynchronous SRAM write controller
`ifndef ASRW_CONSTS_SVH
`define ASRW_CONSTS_SVH

`define ASRW_CLK_PERIOD_NS  50
`define ASRW_T_WP_NS        40
`define ASRW_T_AW_NS        50
`define ASRW_T_CW_NS        50
`define ASRW_T_BW_NS        50
`define ASRW_T_DW_NS        25
`define ASRW_T_WR_NS        0
`define ASRW_T_RC_NS        55
`define ASRW_T_CDR_NS       0
// Least times round up, never below one cycle
`define ASRW_CYC_MIN(t)     ((((t) + `ASRW_CLK_PERIOD_NS - 1) / `ASRW_CLK_PERIOD_NS) < 1 ? 1 : \
	(((t) + `ASRW_CLK_PERIOD_NS - 1) / `ASRW_CLK_PERIOD_NS))
`define ASRW_WP_CYC         `ASRW_CYC_MIN(`ASRW_T_WP_NS)
`define ASRW_SETUP_CYC      `ASRW_CYC_MIN(`ASRW_T_AW_NS)
`define ASRW_WR_CYC         `ASRW_CYC_MIN(`ASRW_T_WR_NS)
`define ASRW_RC_CYC         `ASRW_CYC_MIN(`ASRW_T_RC_NS)
`define ASRW_CDR_CYC        `ASRW_CYC_MIN(`ASRW_T_CDR_NS)
`define ASRW_BE_LOWER_BIT   0
`define ASRW_BE_UPPER_BIT   1

`endif

// File: core/asrw_pkg.sv
// Types for the asynchronous SRAM write controller
package asrw_pkg;
	typedef enum logic [2:0] {
		ASRW_IDLE   = 3'b000,
		ASRW_SETUP  = 3'b001,
		ASRW_PULSE  = 3'b010,
		ASRW_RECOV  = 3'b011,
		ASRW_RET_IN = 3'b100,
		ASRW_RET    = 3'b101,
		ASRW_WAKE   = 3'b110
	} asrw_state_t;
endpackage

// File: core/asrw_ctrl.sv
// Host-side write and retention controller for a 16-bit asynchronous SRAM
`timescale 1ns/1ps
`include "asrw_consts.svh"

// Summary of operation
// - Write overlap held at least 40 ns
// - Address stable 50 ns before write end
// - Chip select low 50 ns before end
// - Byte enables valid 50 ns before end
// - Write data valid 25 ns before end
// - Write recovery of at least 0 ns
// - Byte-enable retention: both high, select low
// - Enter retention before supply starts dropping
module asrw_ctrl
	import asrw_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 16
) (
	input  wire logic              sys_clk_i,
	input  wire logic              srst_i,
	input  wire logic              wr_req_i,
	input  wire logic [ADDR_W-1:0] wr_addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic [1:0]        wr_be_i,
	input  wire logic              ret_req_i,
	input  wire logic              ret_by_be_i,
	output logic                   wr_ready_o,
	output logic                   wr_done_o,
	output logic                   ret_active_o,
	output logic [ADDR_W-1:0]      sram_addr_o,
	output logic                   chip_select_n_o,
	output logic                   write_enable_n_o,
	output logic                   output_enable_n_o,
	output logic                   lower_byte_enable_n_o,
	output logic                   upper_byte_enable_n_o,
	output logic [DATA_W-1:0]      sram_dq_o,
	output logic                   sram_dq_oe_n_o,
	output logic                   sram_addr_oe_n_o
);

	localparam logic [3:0] WP_CYC    = 4'(`ASRW_WP_CYC);
	localparam logic [3:0] SETUP_CYC = 4'(`ASRW_SETUP_CYC);
	localparam logic [3:0] WR_CYC    = 4'(`ASRW_WR_CYC);
	localparam logic [3:0] RC_CYC    = 4'(`ASRW_RC_CYC);
	localparam logic [3:0] CDR_CYC   = 4'(`ASRW_CDR_CYC);

	asrw_state_t state_q;
	logic [3:0]  cnt_q;
	logic        ret_be_q;

	// Timer expiry is tested in several states
	function automatic logic cnt_done(input logic [3:0] c);
		return c <= 4'h1;
	endfunction

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_q <= ASRW_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			unique case (state_q)
				ASRW_IDLE: begin
					if (ret_req_i) begin
						state_q <= ASRW_RET_IN;
						cnt_q   <= CDR_CYC;
					end else if (wr_req_i && wr_be_i != 2'b00) begin
						// Address, select and lanes lead the write strobe
						state_q <= ASRW_SETUP;
						cnt_q   <= SETUP_CYC;
					end
				end
				ASRW_SETUP: begin
					// Strobe falls one setup period after select: met with WP
					state_q <= ASRW_PULSE;
					cnt_q   <= WP_CYC;
				end
				ASRW_PULSE: begin
					if (cnt_done(cnt_q)) begin
						state_q <= ASRW_RECOV;
						cnt_q   <= WR_CYC;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ASRW_RECOV: begin
					if (cnt_done(cnt_q)) begin
						state_q <= ASRW_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ASRW_RET_IN: begin
					if (cnt_done(cnt_q)) begin
						state_q <= ASRW_RET;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ASRW_RET: begin
					if (!ret_req_i) begin
						state_q <= ASRW_WAKE;
						cnt_q   <= RC_CYC;
					end
				end
				ASRW_WAKE: begin
					if (cnt_done(cnt_q)) begin
						state_q <= ASRW_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				default: begin
					state_q <= ASRW_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Retention style, caught when retention is requested
	// ************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ret_be_q <= 1'b0;
		end else if (state_q == ASRW_IDLE && ret_req_i) begin
			ret_be_q <= ret_by_be_i;
		end
	end

	// ************************************************************
	// Pin drive
	// ************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sram_addr_o           <= '0;
			sram_dq_o             <= '0;
			chip_select_n_o       <= 1'b1;
			write_enable_n_o      <= 1'b1;
			output_enable_n_o     <= 1'b1;
			lower_byte_enable_n_o <= 1'b1;
			upper_byte_enable_n_o <= 1'b1;
			sram_dq_oe_n_o        <= 1'b1;
			sram_addr_oe_n_o      <= 1'b0;
			wr_done_o             <= 1'b0;
		end else begin
			wr_done_o <= 1'b0;
			unique case (state_q)
				ASRW_IDLE: begin
					// Output enable stays high so the memory never fights our data
					output_enable_n_o <= 1'b1;
					sram_addr_oe_n_o  <= 1'b0;
					if (ret_req_i) begin
						chip_select_n_o       <= ~ret_by_be_i;
						lower_byte_enable_n_o <= 1'b1;
						upper_byte_enable_n_o <= 1'b1;
						write_enable_n_o      <= 1'b1;
					end else if (wr_req_i && wr_be_i != 2'b00) begin
						sram_addr_o           <= wr_addr_i;
						sram_dq_o             <= wr_data_i;
						sram_dq_oe_n_o        <= 1'b0;
						chip_select_n_o       <= 1'b0;
						lower_byte_enable_n_o <= ~wr_be_i[`ASRW_BE_LOWER_BIT];
						upper_byte_enable_n_o <= ~wr_be_i[`ASRW_BE_UPPER_BIT];
					end
				end
				ASRW_SETUP: begin
					write_enable_n_o <= 1'b0;
				end
				ASRW_PULSE: begin
					if (cnt_done(cnt_q)) begin
						// All strobes rise together, so the write ends on this edge
						write_enable_n_o      <= 1'b1;
						chip_select_n_o       <= 1'b1;
						lower_byte_enable_n_o <= 1'b1;
						upper_byte_enable_n_o <= 1'b1;
						wr_done_o             <= 1'b1;
					end
				end
				ASRW_RECOV: begin
					// Data is held one more cycle past the strobe edge for hold margin
					if (cnt_done(cnt_q)) begin
						sram_dq_oe_n_o <= 1'b1;
					end
				end
				ASRW_RET_IN: begin
					sram_dq_oe_n_o <= 1'b1;
				end
				ASRW_RET: begin
					// Select-held retention floats the address bus; data was floated on entry, controls stay driven
					if (!ret_be_q) begin
						sram_addr_oe_n_o <= 1'b1;
					end
				end
				ASRW_WAKE: begin
					sram_addr_oe_n_o      <= 1'b0;
					chip_select_n_o       <= 1'b1;
					lower_byte_enable_n_o <= 1'b1;
					upper_byte_enable_n_o <= 1'b1;
				end
				default: begin
					chip_select_n_o <= 1'b1;
				end
			endcase
		end
	end

	// The address and data float in select-held retention; the controls stay driven,
	// and the select pin itself is always driven so retention cannot be lost.
	assign wr_ready_o   = (state_q == ASRW_IDLE) && !ret_req_i;
	assign ret_active_o = (state_q == ASRW_RET);

endmodule

// File: tb/asrw_ctrl_asserts.sv
// Pin-timing checker for the SRAM write controller
`timescale 1ns/1ps
module asrw_ctrl_asserts (
	input wire logic        sys_clk_i,
	input wire logic        srst_i,
	input wire logic        wr_ready_o,
	input wire logic        wr_done_o,
	input wire logic        ret_active_o,
	input wire logic [15:0] sram_addr_o,
	input wire logic        chip_select_n_o,
	input wire logic        write_enable_n_o,
	input wire logic        lower_byte_enable_n_o,
	input wire logic        upper_byte_enable_n_o,
	input wire logic        sram_dq_oe_n_o
);
	wire sel = chip_select_n_o;
	wire wen = write_enable_n_o;
	wire boff = lower_byte_enable_n_o & upper_byte_enable_n_o;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	a_pulse_start: assert property ($fell(wen) |-> !sel && !boff) else $error("overlap");
	a_lead_end: assert property ($rose(wen) |-> !$past(sel) && !$past(boff)) else $error("lead");
	a_addr_stable: assert property ($rose(wen) |-> $past(sram_addr_o) == $past(sram_addr_o, 2)) else $error("addr");
	a_data_held: assert property ($rose(wen) |-> !$past(sram_dq_oe_n_o)) else $error("data");
	a_strobes_end: assert property ($rose(wen) |-> sel && boff && wr_done_o) else $error("end");
	a_lane_hold: assert property (ret_active_o && !sel |-> boff && wen) else $error("lanes");
	a_ret_entry: assert property ($rose(ret_active_o) |-> $past(sel) || $past(boff)) else $error("entry");
	a_wake_wait: assert property ($fell(ret_active_o) |-> !wr_ready_o [*2]) else $error("wake");
	cover property ($rose(wr_done_o));
	cover property (ret_active_o && sel);
	cover property (ret_active_o && !sel);
endmodule
bind asrw_ctrl asrw_ctrl_asserts i_asrw_ctrl_asserts (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.wr_ready_o(wr_ready_o), .wr_done_o(wr_done_o), .ret_active_o(ret_active_o), .sram_addr_o(sram_addr_o),
	.chip_select_n_o(chip_select_n_o), .write_enable_n_o(write_enable_n_o),
	.lower_byte_enable_n_o(lower_byte_enable_n_o), .upper_byte_enable_n_o(upper_byte_enable_n_o),
	.sram_dq_oe_n_o(sram_dq_oe_n_o));

// File: tb/asrw_sram_model.sv
// Behavioural 16-bit asynchronous SRAM
`timescale 1ns/1ps
module asrw_sram_model (
	input wire logic        cs_n_i,
	input wire logic        we_n_i,
	input wire logic        oe_n_i,
	input wire logic [1:0]  be_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [15:0] dq_i,
	input wire logic        dq_oe_n_i
);
	logic [15:0] mem [256];
	logic [25:0] k;
	wire         act = !cs_n_i && !we_n_i && be_n_i != 2'h3;
	// Memory would drive its outputs: on 5 ns after a write ends, may linger 20 ns after release
	wire #(5, 20) drv = !cs_n_i && !oe_n_i && we_n_i && be_n_i != 2'h3;
	// Tested on the live pins, not on act, so a half-applied strobe update cannot clobber k
	always @* if (!cs_n_i && !we_n_i && be_n_i != 2'h3) k = {addr_i, ~be_n_i, dq_oe_n_i ? 16'hxxxx : dq_i};
	always @(negedge act) begin
		if (k[16]) mem[k[25:18]][7:0] = k[7:0];
		if (k[17]) mem[k[25:18]][15:8] = k[15:8];
	end
endmodule

// File: tb/asrw_ctrl_tb.sv
// Self-checking bench for the SRAM write controller
`timescale 1ns/1ps
`include "asrw_consts.svh"
module asrw_ctrl_tb;
	logic        sys_clk_i = 1'b0, srst_i = 1'b1, wr_req_i = 1'b0, ret_req_i = 1'b0, ret_by_be_i = 1'b0;
	logic        wr_ready_o, wr_done_o, ret_active_o, chip_select_n_o, write_enable_n_o, output_enable_n_o;
	logic        lower_byte_enable_n_o, upper_byte_enable_n_o, sram_dq_oe_n_o, sram_addr_oe_n_o;
	logic [1:0]  wr_be_i = 2'h0;
	logic [15:0] wr_addr_i = 16'h0, wr_data_i = 16'h0, sram_addr_o, sram_dq_o, exp_m [256];
	int          error_cnt = 0, compares = 0, cyc = 0, n;
	asrw_ctrl i_asrw_ctrl (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i),
		.wr_data_i(wr_data_i), .wr_be_i(wr_be_i), .ret_req_i(ret_req_i), .ret_by_be_i(ret_by_be_i),
		.wr_ready_o(wr_ready_o), .wr_done_o(wr_done_o), .ret_active_o(ret_active_o), .sram_addr_o(sram_addr_o),
		.chip_select_n_o(chip_select_n_o), .write_enable_n_o(write_enable_n_o),
		.output_enable_n_o(output_enable_n_o), .lower_byte_enable_n_o(lower_byte_enable_n_o),
		.upper_byte_enable_n_o(upper_byte_enable_n_o), .sram_dq_o(sram_dq_o), .sram_dq_oe_n_o(sram_dq_oe_n_o),
		.sram_addr_oe_n_o(sram_addr_oe_n_o));
	asrw_sram_model i_asrw_sram_model (.cs_n_i(chip_select_n_o), .we_n_i(write_enable_n_o),
		.oe_n_i(output_enable_n_o),
		.be_n_i({upper_byte_enable_n_o, lower_byte_enable_n_o}), .addr_i(sram_addr_o[7:0]),
		.dq_i(sram_dq_o), .dq_oe_n_i(sram_dq_oe_n_o));
	initial forever #25 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (cyc++ == 2000) begin
		error_cnt++;
		$display("MISMATCH %0t timeout", $time);
		complete_run();
	end
	// Our data drivers must never meet the memory's own outputs
	always @(negedge sys_clk_i) if (!srst_i) chk({15'h0, !sram_dq_oe_n_o && i_asrw_sram_model.drv}, 16'h0);
	function logic [15:0] merge(input logic [15:0] o, d, input logic [1:0] b);
		return {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
	endfunction
	task chk(input logic [15:0] g, e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task complete_run;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Outputs are sampled at falling edges so registered values have settled
	task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
		while (wr_ready_o !== 1'b1) @(negedge sys_clk_i);
		@(posedge sys_clk_i);
		{wr_req_i, wr_addr_i, wr_data_i, wr_be_i} <= {1'b1, 8'h0, a, d, b};
		@(posedge sys_clk_i);
		wr_req_i <= 1'b0;
		for (n = 0; n < 6 && wr_done_o !== 1'b1; n++) @(negedge sys_clk_i);
		exp_m[a] = merge(exp_m[a], d, b);
		chk(i_asrw_sram_model.mem[a], exp_m[a]);
	endtask
	task ret_cycle(input logic s);
		@(posedge sys_clk_i);
		{ret_req_i, ret_by_be_i} <= {1'b1, s};
		for (n = 0; n < 6 && ret_active_o !== 1'b1; n++) @(negedge sys_clk_i);
		chk({13'h0, chip_select_n_o, lower_byte_enable_n_o, upper_byte_enable_n_o}, {13'h0, !s, 2'h3});
		@(negedge sys_clk_i);
		chk({15'h0, sram_addr_oe_n_o}, {15'h0, !s});
		@(posedge sys_clk_i);
		ret_req_i <= 1'b0;
		// Release is seen one edge late, and the first wait ends on the falling edge before that edge, ahead of the wake wait
		for (n = 0; n < 9 && wr_ready_o !== 1'b1; n++) @(negedge sys_clk_i);
		chk({15'h0, n >= 2 + (`ASRW_RC_CYC) && n < 9}, 16'h1);
	endtask
	initial begin
		void'($urandom(32'hdec5));
		repeat (8) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		for (int b = 0; b < 4; b++) wr(8'h12, 16'ha55a ^ {4{4'(b)}}, 2'(b));
		repeat (40) wr(8'($urandom), 16'($urandom), 2'($urandom_range(1, 3)));
		ret_cycle(1'b0);
		ret_cycle(1'b1);
		wr(8'h12, 16'h1234, 2'h3);
		complete_run();
	end
endmodule
